// ### hdl/field_timer.sv
`timescale 1ns/10ps
module field_timer
  import link_err_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             restart_in,
  input  wire logic [CNT_W-1:0] limit_in,
  output logic                  expired_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_expired;

  always_comb
  begin
    next_count   = count;
    next_expired = 1'b0;
    if (restart_in)
      next_count = '0;
    else if (count > limit_in)
      next_expired = 1'b1;
    else
      next_count = count + 1'b1;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      count       <= '0;
      expired_out <= 1'b0;
    end
    else
    begin
      count       <= next_count;
      expired_out <= next_expired;
    end
  end
endmodule

// ### hdl/link_err_pkg.sv
package link_err_pkg;
  localparam logic [15:0] STATUS_ADDR    = 16'h0219;
  localparam int          BIT_RW_DATA    = 6;
  localparam int          BIT_TIMEOUT    = 5;
  localparam int          BIT_CHECKSUM   = 4;
  localparam int          BIT_LEN_PARITY = 3;
  localparam int          BIT_RW_PARITY  = 2;
  localparam int          BIT_HEADER     = 1;
  localparam int          BIT_FRAMING    = 0;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  STATUS_MASK    = 8'h7F;
  localparam logic [7:0]  STATUS_READ_LEN = 8'h01;
  localparam int          TIMEOUT_FIELDS = 3;
  localparam int          RECOVER_FIELDS = 4;
  localparam int          CNT_W          = 20;

  typedef enum logic [1:0]
  {
    ST_STANDBY = 2'b00,
    ST_COMM    = 2'b01,
    ST_ERROR   = 2'b10
  } link_state_t;
endpackage

// ### hdl/serial_link_error_reporter.sv
`timescale 1ns/10ps
// What this block does
// - Nonzero RW bits 5:1 set bit 6, continue
// - Gap over three fields: bit 5, standby
// - Timeout keeps earlier checksum-valid write words
// - Bad write checksum: bit 4, error, drop
// - Length parity bad: bit 3, error mode
// - RW parity bad: bit 2, error mode
// - Header mismatch: bit 1, error mode
// - Low stop bit: bit 0, error mode
// - Line high four fields leaves error mode
// - Status bits stay set until read
// - Single-byte status read clears; multi-byte not
module serial_link_error_reporter
  import link_err_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [CNT_W-1:0] field_cycles_in,
  input  wire logic             line_in,
  input  wire logic             field_done_in,
  input  wire logic             frame_start_in,
  input  wire logic             frame_end_in,
  input  wire logic             write_mode_in,
  input  wire logic             rw_data_err_in,
  input  wire logic             checksum_err_in,
  input  wire logic             len_parity_err_in,
  input  wire logic             rw_parity_err_in,
  input  wire logic             header_err_in,
  input  wire logic             framing_err_in,
  input  wire logic             word_valid_in,
  input  wire logic             read_strobe_in,
  input  wire logic [15:0]      read_addr_in,
  input  wire logic [7:0]       read_len_in,
  output logic [7:0]            status_out,
  output logic [1:0]            link_state_out,
  output logic                  comm_enable_out,
  output logic                  commit_word_out,
  output logic                  drop_data_out
);
  link_state_t state;
  link_state_t next_state;
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic        next_commit;
  logic        next_drop;
  logic        gap_expired;
  logic        high_expired;
  logic        fatal;
  logic        clear_rd;
  logic [7:0]  events;
  logic [CNT_W-1:0] gap_limit;
  logic [CNT_W-1:0] high_limit;
  logic [7:0]  raw_err;
  logic        in_comm;
  logic        restart_gap;
  logic        restart_high;
  logic        next_comm_enable;

  // Only an exact one-byte read of the status address clears; longer reads do not
  function automatic logic single_status_read(input logic        strobe,
                                              input logic [15:0] addr,
                                              input logic [7:0]  len);
    return strobe && (addr == STATUS_ADDR) && (len == STATUS_READ_LEN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timers: three field times between fields, four of line-high to recover
  // Limits are cut to the timer width, so field_cycles_in must stay below 2^18
  assign gap_limit  = CNT_W'(TIMEOUT_FIELDS * field_cycles_in);
  assign high_limit = CNT_W'(RECOVER_FIELDS * field_cycles_in);
  assign in_comm    = (state == ST_COMM);

  // Every completed field opens a fresh gap window
  assign restart_gap  = !in_comm || field_done_in;
  // Any low sample restarts the recovery count
  assign restart_high = (state != ST_ERROR) || !line_in;

  field_timer gap_timer
  (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .restart_in  (restart_gap),
    .limit_in    (gap_limit),
    .expired_out (gap_expired)
  );

  field_timer high_timer
  (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .restart_in  (restart_high),
    .limit_in    (high_limit),
    .expired_out (high_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Error events: raw faults from the frame checker, plus the gap timer timeout
  always_comb
  begin
    raw_err                 = 8'h00;
    raw_err[BIT_RW_DATA]    = rw_data_err_in;
    raw_err[BIT_TIMEOUT]    = gap_expired;
    raw_err[BIT_CHECKSUM]   = write_mode_in && checksum_err_in;
    raw_err[BIT_LEN_PARITY] = len_parity_err_in;
    raw_err[BIT_RW_PARITY]  = rw_parity_err_in;
    raw_err[BIT_HEADER]     = header_err_in;
    raw_err[BIT_FRAMING]    = framing_err_in;
  end

  // Faults seen outside a transaction are stale and must not touch the status
  generate
    for (genvar b = 0; b < $bits(events); b++)
    begin : g_event
      assign events[b] = in_comm && raw_err[b];
    end
  endgenerate

  // Checksum down to framing all end the transaction; RW data fault does not
  assign fatal    = |events[BIT_CHECKSUM:BIT_FRAMING];
  assign clear_rd = single_status_read(read_strobe_in, read_addr_in, read_len_in);

  ////////////////////////////////////////////////////////////////////////////
  // Status byte: set wins over a same-cycle clear
  always_comb
  begin
    next_status = status;
    if (clear_rd)
      next_status = STATUS_RESET;
    next_status = (next_status | events) & STATUS_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state and data fate
  always_comb
  begin
    next_state  = state;
    next_commit = 1'b0;
    next_drop   = 1'b0;
    unique case (state)
      ST_STANDBY:
      begin
        if (frame_start_in)
          next_state = ST_COMM;
      end
      ST_COMM:
      begin
        if (fatal)
        begin
          next_state = ST_ERROR;
          next_drop  = 1'b1;
        end
        else if (gap_expired)
          next_state = ST_STANDBY;
        else
        begin
          // Write data flagged by the RW data error is nullified, link stays up
          next_commit = word_valid_in && write_mode_in && !rw_data_err_in;
          next_drop   = rw_data_err_in && write_mode_in;
          if (frame_end_in)
            next_state = ST_STANDBY;
        end
      end
      ST_ERROR:
      begin
        if (high_expired)
          next_state = ST_STANDBY;
      end
      default:
        next_state = ST_STANDBY;
    endcase
    // Enable follows the state it registers with, so the two never disagree
    next_comm_enable = (next_state == ST_COMM);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Status keeps an internal copy so the output can stay a plain flip-flop
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      status     <= STATUS_RESET;
      status_out <= STATUS_RESET;
    end
    else
    begin
      status     <= next_status;
      status_out <= next_status;
    end
  end

  // State and its visible copies load together so they cannot drift apart
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state           <= ST_STANDBY;
      link_state_out  <= ST_STANDBY;
      comm_enable_out <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      link_state_out  <= next_state;
      comm_enable_out <= next_comm_enable;
    end
  end

  // Data fate strobes last one cycle; the storage side acts on the pulse
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      commit_word_out <= 1'b0;
      drop_data_out   <= 1'b0;
    end
    else
    begin
      commit_word_out <= next_commit;
      drop_data_out   <= next_drop;
    end
  end
endmodule

// ### sim/link_err_chk_assertions.sv
`timescale 1ns/10ps
module link_err_chk
  import link_err_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        write_mode_in,
  input  wire logic        rw_data_err_in,
  input  wire logic        frame_end_in,
  input  wire logic        len_parity_err_in,
  input  wire logic        rw_parity_err_in,
  input  wire logic        checksum_err_in,
  input  wire logic        header_err_in,
  input  wire logic        framing_err_in,
  input  wire logic        read_strobe_in,
  input  wire logic [15:0] read_addr_in,
  input  wire logic [7:0]  read_len_in,
  input  wire logic [7:0]  status_out,
  input  wire logic [1:0]  link_state_out,
  input  wire logic        drop_data_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire comm = link_state_out == ST_COMM;
  property p_rwd;
    comm && rw_data_err_in && !frame_end_in && !len_parity_err_in && !rw_parity_err_in
      && !header_err_in && !framing_err_in && !(write_mode_in && checksum_err_in)
      |=> status_out[BIT_RW_DATA] && comm;
  endproperty
  a_rwd: assert property (p_rwd) else $error("rw data fault not kept in comm");
  property p_tmo; $rose(status_out[BIT_TIMEOUT]) |-> link_state_out == ST_STANDBY; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without standby");
  property p_ck;
    comm && write_mode_in && checksum_err_in |=>
      status_out[BIT_CHECKSUM] && link_state_out == ST_ERROR;
  endproperty
  a_ck: assert property (p_ck) else $error("checksum fault missed");
  property p_hdr; comm && header_err_in |=> status_out[1] && link_state_out == ST_ERROR; endproperty
  a_hdr: assert property (p_hdr) else $error("header fault missed");
  property p_lp;
    comm && len_parity_err_in |=>
      status_out[BIT_LEN_PARITY] && link_state_out == ST_ERROR;
  endproperty
  a_lp: assert property (p_lp) else $error("length parity fault missed");
  property p_rp;
    comm && rw_parity_err_in |=>
      status_out[BIT_RW_PARITY] && link_state_out == ST_ERROR;
  endproperty
  a_rp: assert property (p_rp) else $error("rw parity fault missed");
  property p_drop;
    comm && (len_parity_err_in || rw_parity_err_in || header_err_in || framing_err_in
      || (write_mode_in && (checksum_err_in || rw_data_err_in))) |=> drop_data_out;
  endproperty
  a_drop: assert property (p_drop) else $error("faulty data not dropped");
  property p_frm; comm && framing_err_in |=> status_out[0] ##0 link_state_out == 2'h2; endproperty
  a_frm: assert property (p_frm) else $error("framing fault missed");
  property p_keep;
    !(read_strobe_in && read_addr_in == STATUS_ADDR && read_len_in == 8'h01) |=>
      ($past(status_out) & ~status_out) == 8'h00;
  endproperty
  a_keep: assert property (p_keep) else $error("status bit lost without read");
  property p_clr; read_strobe_in && read_addr_in == STATUS_ADDR && read_len_in == 8'h01
    && link_state_out == ST_STANDBY |=> status_out == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("single byte read did not clear");
  property p_b7; status_out[7] == 1'b0; endproperty
  a_b7: assert property (p_b7) else $error("status bit 7 set");
endmodule

// ### sim/link_master.sv
`timescale 1ns/10ps
module link_master
(
  input  wire logic clk_in,
  input  wire logic idle_in,
  output logic      line_out = 1'b1
);
  // Toggles while busy so a stale high level never fakes a recovery gap
  always @(posedge clk_in)
  begin
    line_out <= idle_in ? 1'b1 : ~line_out;
  end
endmodule

// ### sim/test_serial_link_error_reporter.sv
`timescale 1ns/10ps
module test_serial_link_error_reporter
  import link_err_pkg::*;
;
  localparam logic [CNT_W-1:0] FIELD = 20'h00004;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [9:0]  ev = 10'h000;
  logic        wr = 1'b1;
  logic        rs = 1'b0;
  logic [15:0] ra = 16'h0000;
  logic [7:0]  rl = 8'h00;
  logic        line;
  logic [7:0]  status_out;
  logic [1:0]  state;
  logic        comm_en;
  logic        commit;
  logic        drop;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #12.5 clk_in = ~clk_in;
  link_master master (.clk_in(clk_in), .idle_in(~comm_en), .line_out(line));
  serial_link_error_reporter DUT (.clk_in(clk_in), .reset_in(reset_in),
    .field_cycles_in(FIELD), .line_in(line), .field_done_in(ev[8]),
    .frame_start_in(ev[6]), .frame_end_in(ev[7]), .write_mode_in(wr),
    .rw_data_err_in(ev[5]), .checksum_err_in(ev[4]), .len_parity_err_in(ev[3]),
    .rw_parity_err_in(ev[2]), .header_err_in(ev[1]), .framing_err_in(ev[0]),
    .word_valid_in(ev[9]), .read_strobe_in(rs), .read_addr_in(ra), .read_len_in(rl),
    .status_out(status_out), .link_state_out(state), .comm_enable_out(comm_en),
    .commit_word_out(commit), .drop_data_out(drop));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse_mask(input logic [9:0] bits);
    @(posedge clk_in);
    ev <= bits;
    @(posedge clk_in);
    ev <= 10'h000;
    #1;
  endtask
  task automatic pulse(input int idx);
    pulse_mask(10'h001 << idx);
  endtask
  task automatic rd(input logic [15:0] addr, input logic [7:0] len, input logic [7:0] exp);
    @(posedge clk_in);
    rs <= 1'b1;
    ra <= addr;
    rl <= len;
    @(posedge clk_in);
    rs <= 1'b0;
    #1;
    chk(status_out, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      complete_run;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    chk(status_out, STATUS_RESET);
    for (int i = 0; i < 5; i++)
    begin
      pulse(6);
      pulse(i);
      chk(status_out, 8'h01 << i);
      chk({6'h00, state}, {6'h00, ST_ERROR});
      chk({7'h00, drop}, 8'h01);
      chk({7'h00, comm_en}, 8'h00);
      // Line is high from the error edge on; four fields of it must not release yet
      repeat (RECOVER_FIELDS * FIELD) @(posedge clk_in);
      #1;
      chk({6'h00, state}, {6'h00, ST_ERROR});
      repeat (4) @(posedge clk_in);
      #1;
      chk({6'h00, state}, {6'h00, ST_STANDBY});
      rd(STATUS_ADDR, 8'h02, 8'h01 << i);
      rd(STATUS_ADDR, 8'h01, 8'h00);
      $display("error case %0d done", i);
    end
    @(posedge clk_in);
    wr <= 1'b0;
    pulse(6);
    chk({7'h00, comm_en}, 8'h01);
    pulse(4);
    chk(status_out, 8'h00);
    pulse(5);
    chk(status_out, 8'h40);
    chk({7'h00, drop}, 8'h00);
    chk({6'h00, state}, {6'h00, ST_COMM});
    @(posedge clk_in);
    wr <= 1'b1;
    pulse(9);
    chk({7'h00, commit}, 8'h01);
    // Word, field end and RW data fault together: the word is nullified
    pulse_mask(10'h320);
    chk({7'h00, commit}, 8'h00);
    chk({7'h00, drop}, 8'h01);
    chk({7'h00, comm_en}, 8'h01);
    repeat (TIMEOUT_FIELDS * FIELD) @(posedge clk_in);
    #1;
    chk({6'h00, state}, {6'h00, ST_COMM});
    repeat (3) @(posedge clk_in);
    #1;
    chk(status_out, 8'h60);
    chk({6'h00, state}, {6'h00, ST_STANDBY});
    chk({7'h00, drop}, 8'h00);
    $display("timeout case done");
    // Fault and single-byte read in one cycle: the new fault survives the clear
    pulse(6);
    @(posedge clk_in);
    ev[5] <= 1'b1;
    rs <= 1'b1;
    ra <= STATUS_ADDR;
    rl <= 8'h01;
    @(posedge clk_in);
    ev <= 10'h000;
    rs <= 1'b0;
    #1;
    chk(status_out, 8'h40);
    pulse(7);
    chk({6'h00, state}, {6'h00, ST_STANDBY});
    chk({7'h00, comm_en}, 8'h00);
    rd(STATUS_ADDR + 16'h0001, 8'h01, 8'h40);
    rd(STATUS_ADDR, 8'h01, 8'h00);
    $display("clear case done");
    complete_run;
  end
endmodule
bind serial_link_error_reporter link_err_chk u_chk (.clk_in(clk_in), .reset_in(reset_in),
  .write_mode_in(write_mode_in), .rw_data_err_in(rw_data_err_in),
  .checksum_err_in(checksum_err_in), .header_err_in(header_err_in),
  .framing_err_in(framing_err_in), .read_strobe_in(read_strobe_in),
  .read_addr_in(read_addr_in), .read_len_in(read_len_in), .status_out(status_out),
  .link_state_out(link_state_out), .frame_end_in(frame_end_in),
  .len_parity_err_in(len_parity_err_in), .rw_parity_err_in(rw_parity_err_in),
  .drop_data_out(drop_data_out));
